// [hdl/pwd_defines.svh]
// Constants of the counter-array watchdog: addresses, bit positions, resets
`ifndef PWD_DEFINES_SVH
`define PWD_DEFINES_SVH

// Special function register addresses
`define PWD_ADDR_CTRL        8'hd8
`define PWD_ADDR_MODE        8'hd9
`define PWD_ADDR_CNT_LOW     8'hda
`define PWD_ADDR_CNT_HIGH    8'hdb
`define PWD_ADDR_OFFSET      8'hdc
`define PWD_ADDR_RELOAD      8'hdd
`define PWD_ADDR_MOD4        8'hde

// Control/status register bit positions
`define PWD_CTRL_OVF         7
`define PWD_CTRL_RUN         6
`define PWD_CTRL_MODULE_FOUR_COMPARE_FLAG        4
`define PWD_CTRL_CCF_MSB     4

// Mode register bit positions
`define PWD_MODE_IDLE_SUSP   7
`define PWD_MODE_WD_EN       6
`define PWD_MODE_WD_LOCK     5
`define PWD_MODE_SEL_MSB     3
`define PWD_MODE_SEL_LSB     1
`define PWD_MODE_OVF_IE      0

// Reset values
`define PWD_CTRL_RST         8'h00
`define PWD_MODE_RST         8'h40
`define PWD_BYTE_RST         8'h00
`define PWD_SEL_RST          3'h0

// Clock source codes
`define PWD_SEL_DIV12        3'h0
`define PWD_SEL_DIV4         3'h1
`define PWD_SEL_TIMER0       3'h2
`define PWD_SEL_ECI          3'h3
`define PWD_SEL_SYSCLK       3'h4
`define PWD_SEL_EXT8         3'h5

// Divider counts and counter maxima
`define PWD_DIV_SLOW         4'd12
`define PWD_DIV_FAST         4'd4
`define PWD_DIV_EXT          4'd8
`define PWD_LOW_MAX          8'hff
`define PWD_CNT_MAX          16'hffff

`endif

// [hdl/pwd_pkg.sv]
// Types shared by the counter-array watchdog modules
package pwd_pkg;
    typedef logic [7:0] pwd_byte_t;
    typedef logic [2:0] pwd_clk_sel_t;
    typedef logic [15:0] pwd_count_t;
endpackage

// [hdl/pwd_cnt_if.sv]
// Signals between the watchdog top, its tick source and its compare unit
`timescale 1ns/1ps
`default_nettype none
interface pwd_cnt_if;
    pwd_pkg::pwd_clk_sel_t clk_sel;
    logic                  tick;
    pwd_pkg::pwd_byte_t    cnt_high;
    logic                  low_wrap;
    pwd_pkg::pwd_byte_t    offset;
    logic                  reload_wr;
    logic                  wd_en;
    logic                  force_rst;
    pwd_pkg::pwd_byte_t    reload;
    logic                  wd_rst;

    modport src (input clk_sel, output tick);
    modport wdt (input cnt_high, low_wrap, offset, reload_wr, wd_en,
                 force_rst, output reload, wd_rst);
    modport ctl (output clk_sel, cnt_high, low_wrap, offset, reload_wr,
                 wd_en, force_rst, input tick, reload, wd_rst);
endinterface
`default_nettype wire

// [hdl/pwd_tick_gen.sv]
// Counter-array clock source: prescalers, pin synchronisers, selector
`timescale 1ns/1ps
`default_nettype none
`include "pwd_defines.svh"
module pwd_tick_gen (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic arst_n_in,
    // Tick sources
    input  wire logic timer0_ovf_in,
    input  wire logic eci_pin_in,
    input  wire logic ext_clk_pin_in,
    // Selection and tick
    pwd_cnt_if.src    cnt_if
);
    logic [3:0] div_r;
    logic [3:0] ext_div_r;
    logic [2:0] eci_sh_r;
    logic [2:0] ext_sh_r;
    logic       eci_fall;
    logic       ext_rise;
    logic       tick_nxt;

    // Pins pass two flops before any edge detection
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            eci_sh_r <= 3'h0;
            ext_sh_r <= 3'h0;
        end else begin
            eci_sh_r <= {eci_sh_r[1:0], eci_pin_in};
            ext_sh_r <= {ext_sh_r[1:0], ext_clk_pin_in};
        end
    end

    assign eci_fall = eci_sh_r[2] & ~eci_sh_r[1];
    assign ext_rise = ext_sh_r[1] & ~ext_sh_r[2];

    // One prescaler serves both the /12 and /4 taps
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_r <= 4'h0;
        end else if (div_r == `PWD_DIV_SLOW - 4'd1) begin
            div_r <= 4'h0;
        end else begin
            div_r <= div_r + 4'd1;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ext_div_r <= 4'h0;
        end else if (ext_rise) begin
            if (ext_div_r == `PWD_DIV_EXT - 4'd1) begin
                ext_div_r <= 4'h0;
            end else begin
                ext_div_r <= ext_div_r + 4'd1;
            end
        end
    end

    always_comb begin
        case (cnt_if.clk_sel)
            `PWD_SEL_DIV12:  tick_nxt = (div_r == `PWD_DIV_SLOW - 4'd1);
            `PWD_SEL_DIV4:   tick_nxt = (div_r[1:0] == 2'h3);
            `PWD_SEL_TIMER0: tick_nxt = timer0_ovf_in;
            `PWD_SEL_ECI:    tick_nxt = eci_fall;
            `PWD_SEL_SYSCLK: tick_nxt = 1'b1;
            `PWD_SEL_EXT8:   tick_nxt = ext_rise &
                                        (ext_div_r == `PWD_DIV_EXT - 4'd1);
            default:         tick_nxt = 1'b0;
        endcase
    end

    assign cnt_if.tick = tick_nxt;

    a_div12_period: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (div_r == `PWD_DIV_SLOW - 4'd1) |=>
        (div_r != `PWD_DIV_SLOW - 4'd1) [*8] ##1
        (div_r != `PWD_DIV_SLOW - 4'd1) [*3] ##1
        (div_r == `PWD_DIV_SLOW - 4'd1))
        else $error("divide by 12 tick spacing wrong");
endmodule // pwd_tick_gen
`default_nettype wire

// [hdl/pwd_wdt_core.sv]
// Watchdog reload register, high-byte compare and reset pulse
`timescale 1ns/1ps
`default_nettype none
`include "pwd_defines.svh"
module pwd_wdt_core (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic arst_n_in,
    // Counter and control view
    pwd_cnt_if.wdt    cnt_if
);
    pwd_pkg::pwd_byte_t reload_r;
    logic               wd_rst_r;
    logic               match;

    // Any write reloads from the counter, the written value is dropped
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reload_r <= `PWD_BYTE_RST;
        end else if (cnt_if.reload_wr) begin
            reload_r <= 8'(cnt_if.cnt_high + cnt_if.offset);
        end
    end

    // Compare uses the high byte before the carry lands, which gives
    // offset*256 plus what the low byte still had to run
    assign match = (reload_r == cnt_if.cnt_high);

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wd_rst_r <= 1'b0;
        end else begin
            wd_rst_r <= cnt_if.wd_en &
                        ((cnt_if.low_wrap & match) |
                         cnt_if.force_rst);
        end
    end

    assign cnt_if.reload = reload_r;
    assign cnt_if.wd_rst = wd_rst_r;

    a_reload_value: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        cnt_if.reload_wr |=>
        reload_r == 8'($past(cnt_if.cnt_high) + $past(cnt_if.offset)))
        else $error("reload not counter high plus offset");
    a_rst_cause: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        $rose(wd_rst_r) |-> $past(cnt_if.wd_en) &&
        ($past(cnt_if.force_rst) ||
         ($past(cnt_if.low_wrap) &&
          $past(reload_r) == $past(cnt_if.cnt_high))))
        else $error("watchdog reset without cause");
    a_force_rst: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (cnt_if.wd_en && cnt_if.force_rst) |=> wd_rst_r)
        else $error("forced reset missing");
endmodule // pwd_wdt_core
`default_nettype wire

// [hdl/pwd_watchdog.sv]
// Counter-array watchdog top: registers, 16-bit counter, flags
// What this block does
// - Timeout equals 256 times offset plus 256 minus low byte at reload.
// - Reset when low byte overflows while reload byte equals high byte.
// - Writing one to module-four flag while enabled resets at once.
// - Clock select and idle-suspend writes are ignored while enabled.
// - Watchdog is on when the enable bit or the lock bit is set.
// - Lock bit keeps the watchdog on until the next reset.
// - Without lock, clearing the enable bit turns the watchdog off.
// - Reset leaves watchdog on, clock divided by 12, bytes zero.
// - Default settings give a timeout of 256 counter ticks.
// - Idle-suspend bit stops counting while the processor idles.
// - Overflow flag sets when the counter wraps from all ones.
// - Set overflow flag with its enable raises the interrupt request.
// - Run-control starts and stops the counter unless the watchdog forces it.
// - Reload write loads counter high byte plus offset, ignoring data.
// - Enabled watchdog keeps the counter running regardless of run-control.
// - Enabled watchdog blocks counter byte and module-four mode writes.
`timescale 1ns/1ps
`default_nettype none
`include "pwd_defines.svh"
module pwd_watchdog (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       arst_n_in,
    // Special function register port
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic [7:0] sfr_wdata_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    output logic      [7:0] sfr_rdata_out,
    // Core status and tick sources
    input  wire logic       cpu_idle_in,
    input  wire logic       timer0_ovf_in,
    // Pins
    input  wire logic       eci_pin_in,
    input  wire logic       ext_clk_pin_in,
    // System outputs
    output logic            wdt_reset_out,
    output logic            pca_irq_out
);
    pwd_cnt_if cnt_if ();

    pwd_pkg::pwd_count_t   cnt_r;
    pwd_pkg::pwd_byte_t    offset_r;
    pwd_pkg::pwd_byte_t    mod4_r;
    pwd_pkg::pwd_byte_t    rdata_r;
    pwd_pkg::pwd_clk_sel_t clk_sel_r;
    logic [3:0]            ccf_low_r;
    logic                  module_four_compare_flag_r;
    logic                  ovf_flag_r;
    logic                  run_r;
    logic                  idle_susp_r;
    logic                  wd_en_bit_r;
    logic                  wd_lock_r;
    logic                  ovf_ie_r;
    logic                  irq_r;
    logic                  wd_en;
    logic                  count_en;
    logic                  wr_ctrl;
    logic                  wr_mode;
    logic                  wr_low;
    logic                  wr_high;
    logic                  wr_offset;
    logic                  wr_mod4;

    pwd_tick_gen u_tick (
        .mclk_in        (mclk_in),
        .arst_n_in      (arst_n_in),
        .timer0_ovf_in  (timer0_ovf_in),
        .eci_pin_in     (eci_pin_in),
        .ext_clk_pin_in (ext_clk_pin_in),
        .cnt_if         (cnt_if)
    );

    pwd_wdt_core u_wdt (
        .mclk_in   (mclk_in),
        .arst_n_in (arst_n_in),
        .cnt_if    (cnt_if)
    );

    // Address decode
    assign wr_ctrl   = sfr_wr_in & (sfr_addr_in == `PWD_ADDR_CTRL);
    assign wr_mode   = sfr_wr_in & (sfr_addr_in == `PWD_ADDR_MODE);
    assign wr_low    = sfr_wr_in & (sfr_addr_in == `PWD_ADDR_CNT_LOW);
    assign wr_high   = sfr_wr_in & (sfr_addr_in == `PWD_ADDR_CNT_HIGH);
    assign wr_offset = sfr_wr_in & (sfr_addr_in == `PWD_ADDR_OFFSET);
    assign wr_mod4   = sfr_wr_in & (sfr_addr_in == `PWD_ADDR_MOD4);

    assign wd_en = wd_en_bit_r | wd_lock_r;

    // Watchdog forces counting; idle suspend still applies
    assign count_en = cnt_if.tick & (run_r | wd_en) &
                      ~(idle_susp_r & cpu_idle_in);

    // Mode register: clock select and idle choice freeze while enabled
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            idle_susp_r <= 1'(`PWD_MODE_RST >> `PWD_MODE_IDLE_SUSP);
            wd_en_bit_r <= 1'b1;
            wd_lock_r   <= 1'b0;
            clk_sel_r   <= `PWD_SEL_RST;
            ovf_ie_r    <= 1'b0;
        end else if (wr_mode) begin
            ovf_ie_r    <= sfr_wdata_in[`PWD_MODE_OVF_IE];
            wd_en_bit_r <= sfr_wdata_in[`PWD_MODE_WD_EN];
            // Lock is sticky: only a reset can release it
            wd_lock_r   <= wd_lock_r |
                           sfr_wdata_in[`PWD_MODE_WD_LOCK];
            if (!wd_en) begin
                idle_susp_r <= sfr_wdata_in[`PWD_MODE_IDLE_SUSP];
                clk_sel_r   <= sfr_wdata_in[`PWD_MODE_SEL_MSB:
                                            `PWD_MODE_SEL_LSB];
            end
        end
    end

    // Counter low byte: software write only when watchdog is off
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_r[7:0] <= `PWD_BYTE_RST;
        end else if (wr_low && !wd_en) begin
            cnt_r[7:0] <= sfr_wdata_in;
        end else if (count_en) begin
            cnt_r[7:0] <= cnt_r[7:0] + 8'h01;
        end
    end

    // Counter high byte takes the carry out of the low byte
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_r[15:8] <= `PWD_BYTE_RST;
        end else if (wr_high && !wd_en) begin
            cnt_r[15:8] <= sfr_wdata_in;
        end else if (count_en && cnt_r[7:0] == `PWD_LOW_MAX) begin
            cnt_r[15:8] <= cnt_r[15:8] + 8'h01;
        end
    end

    // Offset byte stays writable so a reload can pick up a new timeout
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            offset_r <= `PWD_BYTE_RST;
        end else if (wr_offset) begin
            offset_r <= sfr_wdata_in;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mod4_r <= `PWD_BYTE_RST;
        end else if (wr_mod4 && !wd_en) begin
            mod4_r <= sfr_wdata_in;
        end
    end

    // Control/status: a wrap in the same cycle as a clear keeps the flag
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ovf_flag_r <= 1'b0;
        end else if (count_en && cnt_r == `PWD_CNT_MAX) begin
            ovf_flag_r <= 1'b1;
        end else if (wr_ctrl) begin
            ovf_flag_r <= sfr_wdata_in[`PWD_CTRL_OVF];
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            run_r     <= 1'b0;
            module_four_compare_flag_r    <= 1'b0;
            ccf_low_r <= 4'h0;
        end else if (wr_ctrl) begin
            run_r     <= sfr_wdata_in[`PWD_CTRL_RUN];
            module_four_compare_flag_r    <= sfr_wdata_in[`PWD_CTRL_MODULE_FOUR_COMPARE_FLAG];
            ccf_low_r <= sfr_wdata_in[`PWD_CTRL_MODULE_FOUR_COMPARE_FLAG-1:0];
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= ovf_flag_r & ovf_ie_r;
        end
    end

    // Read data is registered: the byte appears the cycle after the strobe
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_r <= `PWD_BYTE_RST;
        end else if (sfr_rd_in) begin
            case (sfr_addr_in)
                `PWD_ADDR_CTRL:     rdata_r <= {ovf_flag_r, run_r, 1'b0,
                                                module_four_compare_flag_r, ccf_low_r};
                `PWD_ADDR_MODE:     rdata_r <= {idle_susp_r, wd_en_bit_r,
                                                wd_lock_r, 1'b0,
                                                clk_sel_r, ovf_ie_r};
                `PWD_ADDR_CNT_LOW:  rdata_r <= cnt_r[7:0];
                `PWD_ADDR_CNT_HIGH: rdata_r <= cnt_r[15:8];
                `PWD_ADDR_OFFSET:   rdata_r <= offset_r;
                `PWD_ADDR_RELOAD:   rdata_r <= cnt_if.reload;
                `PWD_ADDR_MOD4:     rdata_r <= mod4_r;
                default:            rdata_r <= 8'h00;
            endcase
        end
    end

    // Interface drive toward tick source and compare unit
    assign cnt_if.clk_sel   = clk_sel_r;
    assign cnt_if.cnt_high  = cnt_r[15:8];
    assign cnt_if.low_wrap  = count_en & (cnt_r[7:0] == `PWD_LOW_MAX);
    assign cnt_if.offset    = offset_r;
    assign cnt_if.reload_wr = sfr_wr_in &
                              (sfr_addr_in == `PWD_ADDR_RELOAD);
    assign cnt_if.wd_en     = wd_en;
    // Writing one here while enabled is a deliberate software reset
    assign cnt_if.force_rst = wr_ctrl & sfr_wdata_in[`PWD_CTRL_MODULE_FOUR_COMPARE_FLAG];

    assign sfr_rdata_out = rdata_r;
    assign wdt_reset_out = cnt_if.wd_rst;
    assign pca_irq_out   = irq_r;

    a_sel_frozen: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        wd_en |=> $stable(clk_sel_r) && $stable(idle_susp_r))
        else $error("clock select changed while enabled");

    a_lock_holds: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        wd_lock_r |=> wd_lock_r && wd_en)
        else $error("lock released before reset");

    a_disable_ok: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (wr_mode && !wd_lock_r && !sfr_wdata_in[`PWD_MODE_WD_EN] &&
         !sfr_wdata_in[`PWD_MODE_WD_LOCK]) |=> !wd_en)
        else $error("enable bit clear did not disable");

    a_idle_stops: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (idle_susp_r && cpu_idle_in && !wr_low && !wr_high) |=>
        $stable(cnt_r))
        else $error("counter moved during idle suspend");

    a_wrap_flag: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (count_en && cnt_r == `PWD_CNT_MAX) |=>
        ovf_flag_r && cnt_r == 16'h0000)
        else $error("overflow flag not set on wrap");

    a_irq_follow: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (ovf_flag_r && ovf_ie_r) |=> pca_irq_out)
        else $error("interrupt request missing");

    a_stop_holds: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (!run_r && !wd_en && !wr_low && !wr_high) |=> $stable(cnt_r))
        else $error("stopped counter moved");

    a_forced_run: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (wd_en && cnt_if.tick && !(idle_susp_r && cpu_idle_in)) |=>
        cnt_r == 16'($past(cnt_r) + 16'h0001))
        else $error("counter not forced on by watchdog");

    a_timeout_pulse: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (wd_en && cnt_if.low_wrap && cnt_if.reload == cnt_r[15:8]) |=>
        wdt_reset_out)
        else $error("timeout did not reset");

    // Register and counter guards
    a_mod4_frozen: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (wd_en && wr_mod4) |=> $stable(mod4_r))
        else $error("module-four mode written while enabled");

    // Only software may clear the flag
    a_ovf_sticky: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (ovf_flag_r && !wr_ctrl) |=> ovf_flag_r)
        else $error("overflow flag cleared by hardware");

    a_count_step: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (count_en && !wr_low && !wr_high) |=>
        cnt_r == 16'($past(cnt_r) + 16'h0001))
        else $error("counter did not advance by one");

    a_run_write: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        wr_ctrl |=> run_r == $past(sfr_wdata_in[`PWD_CTRL_RUN]))
        else $error("run control not stored");

    a_lock_sets: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (wr_mode && sfr_wdata_in[`PWD_MODE_WD_LOCK]) |=>
        wd_lock_r && wd_en)
        else $error("lock write did not enable");
endmodule // pwd_watchdog
`default_nettype wire

// [bench/test_pwd_watchdog.sv]
// Self-checking bench for the counter-array watchdog
`timescale 1ns/1ps
`default_nettype none
`include "pwd_defines.svh"
module test_pwd_watchdog;
    logic        mclk_in;
    logic        arst_n_in;
    logic [7:0]  sfr_addr_in;
    logic [7:0]  sfr_wdata_in;
    logic        sfr_wr_in;
    logic        sfr_rd_in;
    logic [7:0]  sfr_rdata_out;
    logic        cpu_idle_in;
    logic        timer0_ovf_in;
    logic        eci_pin_in;
    logic        ext_clk_pin_in;
    logic        wdt_reset_out;
    logic        pca_irq_out;
    logic [31:0] seed;
    logic [7:0]  rd;
    logic [7:0]  lo;
    logic [7:0]  ofs;
    logic [7:0]  rst_tab [7];
    int          fails;
    int          total_checks;
    int          cyc;
    int          t0;
    int          en_m, lk_m, sel_m, idl_m, ie_m;
    localparam int LIMIT = 30000;

    pwd_watchdog dut (
        .mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
        .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
        .sfr_rdata_out(sfr_rdata_out), .cpu_idle_in(cpu_idle_in),
        .timer0_ovf_in(timer0_ovf_in), .eci_pin_in(eci_pin_in),
        .ext_clk_pin_in(ext_clk_pin_in), .wdt_reset_out(wdt_reset_out),
        .pca_irq_out(pca_irq_out)
    );

    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Unselected tick sources still toggle so their logic is exercised
    always @(posedge mclk_in) begin
        seed <= xs(seed);
        timer0_ovf_in <= seed[0];
        eci_pin_in <= seed[1];
        ext_clk_pin_in <= seed[2];
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails++;
            final_report();
        end
    end

    // Mode register model: enabled state freezes clock and idle fields
    task automatic m_mode(input logic [7:0] d);
        if (en_m == 0 && lk_m == 0) begin
            sel_m = d[3:1];
            idl_m = d[7];
        end
        en_m = d[6];
        lk_m = lk_m | d[5];
        ie_m = d[0];
    endtask

    function automatic logic [7:0] m_val();
        return {idl_m[0], en_m[0], lk_m[0], 1'b0, sel_m[2:0], ie_m[0]};
    endfunction

    task automatic do_reset();
        arst_n_in <= 1'b0;
        repeat (8) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        en_m = 1;
        lk_m = 0;
        sel_m = 0;
        idl_m = 0;
        ie_m = 0;
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_in <= 1'b1;
        @(posedge mclk_in);
        sfr_wr_in <= 1'b0;
        if (a == `PWD_ADDR_MODE) m_mode(d);
        #1;
    endtask

    task automatic sfr_rd(input logic [7:0] a);
        @(posedge mclk_in);
        sfr_addr_in <= a;
        sfr_rd_in <= 1'b1;
        @(posedge mclk_in);
        sfr_rd_in <= 1'b0;
        #1;
        rd = sfr_rdata_out;
    endtask

    task automatic chk_byte(input string nm, input logic [7:0] e,
                            input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", nm, e, s);
        end
    endtask

    // Cycle counts carry a small slack for strobe and register latency
    task automatic chk_time(input string nm, input int e, input int s);
        total_checks++;
        if (s < e - 4 || s > e + 4) begin
            fails++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, s);
        end
    endtask

    task automatic wait_rst(input int lim);
        int n;
        n = 0;
        while (wdt_reset_out !== 1'b1 && n < lim) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        arst_n_in = 1'b0;
        sfr_addr_in = 8'h00;
        sfr_wdata_in = 8'h00;
        sfr_wr_in = 1'b0;
        sfr_rd_in = 1'b0;
        cpu_idle_in = 1'b0;
        timer0_ovf_in = 1'b0;
        eci_pin_in = 1'b0;
        ext_clk_pin_in = 1'b0;
        seed = 32'd48470;
        fails = 0;
        total_checks = 0;
        cyc = 0;
        rst_tab = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
        do_reset();
        t0 = cyc;
        foreach (rst_tab[i]) begin
            sfr_rd(i < 5 ? 8'hda + i[7:0] : 8'hd8 + i[7:0] - 8'h05);
            chk_byte("reset_value", rst_tab[i], rd);
        end
        sfr_rd(8'he0);
        chk_byte("unmapped", 8'h00, rd);
        wait_rst(4000);
        chk_time("default_timeout", 3072, cyc - t0);
        $display("done default_timeout");
        sfr_wr(`PWD_ADDR_MODE, 8'h48);
        sfr_rd(`PWD_ADDR_MODE);
        chk_byte("frozen_mode", m_val(), rd);
        sfr_wr(`PWD_ADDR_CNT_LOW, 8'h77);
        sfr_rd(`PWD_ADDR_CNT_LOW);
        chk_bit("low_blocked", 1'b0, rd == 8'h77);
        sfr_wr(`PWD_ADDR_MOD4, 8'h55);
        sfr_rd(`PWD_ADDR_MOD4);
        chk_byte("mod4_blocked", 8'h00, rd);
        sfr_wr(`PWD_ADDR_CTRL, 8'h10);
        chk_bit("forced_reset", 1'b1, wdt_reset_out);
        @(posedge mclk_in);
        #1;
        chk_bit("pulse_end", 1'b0, wdt_reset_out);
        $display("done enabled_limits");
        sfr_wr(`PWD_ADDR_MODE, 8'h00);
        sfr_wr(`PWD_ADDR_CTRL, 8'h10);
        chk_bit("no_force_off", 1'b0, wdt_reset_out);
        sfr_wr(`PWD_ADDR_MODE, 8'h09);
        sfr_rd(`PWD_ADDR_MODE);
        chk_byte("mode_open", m_val(), rd);
        sfr_wr(`PWD_ADDR_CTRL, 8'h00);
        sfr_wr(`PWD_ADDR_CNT_LOW, 8'hf0);
        sfr_wr(`PWD_ADDR_CNT_HIGH, 8'hff);
        repeat (4) @(posedge mclk_in);
        sfr_rd(`PWD_ADDR_CNT_LOW);
        chk_byte("stopped_low", 8'hf0, rd);
        sfr_wr(`PWD_ADDR_CTRL, 8'h40);
        repeat (20) @(posedge mclk_in);
        sfr_rd(`PWD_ADDR_CTRL);
        chk_byte("overflow_flag", 8'hc0, rd);
        chk_bit("irq_set", 1'b1, pca_irq_out);
        sfr_wr(`PWD_ADDR_CTRL, 8'h40);
        repeat (2) @(posedge mclk_in);
        #1;
        chk_bit("irq_clear", 1'b0, pca_irq_out);
        $display("done overflow");
        sfr_wr(`PWD_ADDR_MODE, 8'h88);
        @(posedge mclk_in);
        cpu_idle_in <= 1'b1;
        sfr_wr(`PWD_ADDR_CNT_LOW, 8'h10);
        repeat (5) @(posedge mclk_in);
        sfr_rd(`PWD_ADDR_CNT_LOW);
        chk_byte("idle_hold", 8'h10, rd);
        cpu_idle_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        sfr_rd(`PWD_ADDR_CNT_LOW);
        chk_bit("idle_resume", 1'b1, rd != 8'h10);
        sfr_wr(`PWD_ADDR_CTRL, 8'h00);
        $display("done idle_suspend");
        // Divide-by-4 source: 42 counted edges give about ten ticks
        sfr_wr(`PWD_ADDR_MODE, 8'h02);
        sfr_wr(`PWD_ADDR_CNT_LOW, 8'h00);
        sfr_wr(`PWD_ADDR_CTRL, 8'h40);
        repeat (40) @(posedge mclk_in);
        sfr_wr(`PWD_ADDR_CTRL, 8'h00);
        sfr_rd(`PWD_ADDR_CNT_LOW);
        chk_time("div4_ticks", 42 / 4, rd);
        $display("done div4_source");
        // Configure in documented order, then time the reload to reset
        repeat (2) begin
            lo = seed[7:0] & 8'h7f;
            ofs = {6'h00, seed[9:8]};
            sfr_wr(`PWD_ADDR_MODE, 8'h00);
            sfr_wr(`PWD_ADDR_MODE, 8'h08);
            sfr_wr(`PWD_ADDR_CNT_LOW, lo);
            sfr_wr(`PWD_ADDR_CNT_HIGH, 8'h00);
            sfr_wr(`PWD_ADDR_OFFSET, ofs);
            sfr_wr(`PWD_ADDR_MODE, 8'h48);
            sfr_wr(`PWD_ADDR_RELOAD, 8'h5a);
            t0 = cyc;
            sfr_rd(`PWD_ADDR_RELOAD);
            chk_byte("reload_value", ofs, rd);
            wait_rst(2000);
            chk_time("timeout", 256 * ofs + 256 - lo, cyc - t0);
        end
        $display("done offset_timeout");
        do_reset();
        sfr_wr(`PWD_ADDR_MODE, 8'h28);
        sfr_rd(`PWD_ADDR_MODE);
        chk_byte("lock_set", m_val(), rd);
        sfr_wr(`PWD_ADDR_MODE, 8'h00);
        sfr_rd(`PWD_ADDR_MODE);
        chk_byte("lock_held", m_val(), rd);
        sfr_wr(`PWD_ADDR_CNT_LOW, 8'h77);
        sfr_rd(`PWD_ADDR_CNT_LOW);
        chk_bit("lock_blocks", 1'b0, rd == 8'h77);
        wait_rst(4000);
        chk_bit("lock_timeout", 1'b1, wdt_reset_out);
        do_reset();
        sfr_rd(`PWD_ADDR_MODE);
        chk_byte("lock_cleared", 8'h40, rd);
        $display("done lock");
        final_report();
    end
endmodule // test_pwd_watchdog
`default_nettype wire
